// File: pmrb_map.svh
`ifndef PMRB_MAP_SVH
`define PMRB_MAP_SVH
// Register offsets of the main map.
`define PMRB_ADDR_TARGET     8'h00
`define PMRB_ADDR_SOFT_RESET_CONTROL  8'h01
`define PMRB_ADDR_STATUS     8'h04
`define PMRB_ADDR_OUT_PAGE   8'h32
`define PMRB_ADDR_RX_PAGE    8'h4c
// Range limits.
`define PMRB_SHARED_HI       8'h32
`define PMRB_OUT_LO          8'h33
`define PMRB_OUT_HI          8'h3a
`define PMRB_EQ_LO           8'h40
`define PMRB_EQ_HI           8'h45
`define PMRB_RX_LO           8'h46
`define PMRB_RX_HI           8'h7f
`define PMRB_ODBG_LO         8'h90
`define PMRB_ODBG_HI         8'h9f
`define PMRB_IND_LO          8'hb0
`define PMRB_IND_HI          8'hbf
`define PMRB_RDBG_LO         8'hd0
`define PMRB_RDBG_HI         8'hdf
`define PMRB_ID_LO           8'hf0
`define PMRB_ID_HI           8'hf5
`define PMRB_PADDR_LO        8'hf8
`define PMRB_PADDR_HI        8'hfb
// Field positions.
`define PMRB_BIT_OVERRIDE    0
`define PMRB_BIT_KEEP_RST    0
`define PMRB_BIT_FULL_RST    1
`define PMRB_BIT_RELOAD      2
`define PMRB_BIT_INIT_DONE   6
`define PMRB_BIT_OUT_WEN     0
`define PMRB_BIT_OUT_RSEL    4
`define PMRB_RX_RSEL_LO      4
// Reset values and timing.
`define PMRB_RST_BYTE        8'h00
`define PMRB_LOAD_CYCLES     6'h20
`define PMRB_RX_PORTS        4
`endif

// File: pmrb_pkg.sv
package pmrb_pkg;
  typedef enum logic [2:0] {
    PMRB_SHARED  = 3'b000,
    PMRB_OUT_PG  = 3'b001,
    PMRB_RX_PG   = 3'b010,
    PMRB_RSVD    = 3'b011
  } pmrb_region_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmrb_req_s;
  typedef enum logic [1:0] {
    PMRB_LOADING = 2'b00,
    PMRB_READY   = 2'b01
  } pmrb_load_e;
endpackage

// File: pmrb_ram.sv
`timescale 1ns/1ps
// Byte-wide register storage with registered read data.
module pmrb_ram (
  input  wire logic       CLK_IN,     // Clock.
  input  wire logic       we_in,      // Write strobe.
  input  wire logic [9:0] waddr_in,   // Write address.
  input  wire logic [7:0] wdata_in,   // Write data.
  input  wire logic [9:0] raddr_in,   // Read address.
  output logic      [7:0] rdata_out   // Registered read data.
);
  logic [7:0] mem [0:1023];
  // Storage holds no reset so it maps onto plain memory.
  always_ff @(posedge CLK_IN) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule

// File: pmrb_top.sv
`timescale 1ns/1ps
`include "pmrb_map.svh"
// Functional notes
// - Registers reachable from local I2C port and from link control channel.
// - 0x33-0x3A output page; read when 0x32[4]=0, write when 0x32[0]=1.
// - 0x46-0x7F read port by 0x4C[5:4]; write all ports enabled in 0x4C.
// - 0xD0-0xDF paged per receive port like the main receive range.
// - 0x90-0x9F is one shared output debug block.
// - ID range and other listed ranges are shared, not paged.
// - Register 0x00 bits 7:1 always show the target address in use.
// - Override clear: address read-only, strapped value used.
// - Override set: written address replaces the strapped address.
// - Bit 2 of 0x01 restarts ROM load and clears itself.
// - Bit 1 resets logic, target address, paging registers and ROM load, not the memory-held registers, then clears itself.
// - Bit 0 resets logic but keeps configuration registers; self-clearing.
// - Status bit 6 sets once ROM loading finishes.
module pmrb_top (
  input  wire logic       CLK_IN,          // Clock, 125 MHz.
  input  wire logic       RST_N_IN,        // Asynchronous reset, low.
  input  wire logic [6:0] STRAP_ADDR_IN,   // Strapped target address.
  input  wire logic       LCL_WR_IN,       // Local I2C write strobe.
  input  wire logic       LCL_RD_IN,       // Local I2C read strobe.
  input  wire logic [7:0] LCL_ADDR_IN,     // Local register address.
  input  wire logic [7:0] LCL_WDATA_IN,    // Local write data.
  input  wire logic       CH_WR_IN,        // Channel write strobe.
  input  wire logic       CH_RD_IN,        // Channel read strobe.
  input  wire logic [7:0] CH_ADDR_IN,      // Channel register address.
  input  wire logic [7:0] CH_WDATA_IN,     // Channel write data.
  output logic      [7:0] RDATA_OUT,       // Read data, registered.
  output logic            RVALID_OUT,      // Read data valid pulse.
  output logic            CH_BUSY_OUT,     // Channel stalled this cycle.
  output logic      [6:0] TARGET_ADDR_OUT, // Address in use.
  output logic            LOGIC_RST_OUT,   // Digital logic reset pulse.
  output logic            INIT_DONE_OUT    // ROM load finished.
);
  pmrb_pkg::pmrb_req_s req;
  pmrb_pkg::pmrb_region_e region;
  pmrb_pkg::pmrb_load_e load_state;
  logic [7:0] out_page;
  logic [7:0] rx_page;
  logic       override;
  logic [6:0] target_addr;
  logic [6:0] strap_latch;
  logic       strap_taken;
  logic       full_rst;
  logic [5:0] load_cnt;
  logic       rd_pend;
  logic       rd_mem;
  logic [7:0] rd_reg;
  logic       mem_we;
  logic [9:0] mem_waddr;
  logic [9:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [3:0] wport_mask;
  logic       bcast_busy;
  logic [7:0] bcast_addr;
  logic [7:0] bcast_data;
  logic [3:0] bcast_left;

  // Local wins; a busy channel request is kept off the bus so it acts once.
  always_comb begin
    if (LCL_WR_IN || LCL_RD_IN) begin
      req = '{LCL_WR_IN, LCL_RD_IN, LCL_ADDR_IN, LCL_WDATA_IN};
    end else if (bcast_busy) begin
      req = '0;
    end else begin
      req = '{CH_WR_IN, CH_RD_IN, CH_ADDR_IN, CH_WDATA_IN};
    end
  end
  assign CH_BUSY_OUT = (LCL_WR_IN || LCL_RD_IN || bcast_busy) &&
                       (CH_WR_IN || CH_RD_IN);

  // Region decode of the main map.
  always_comb begin
    if (req.addr <= `PMRB_SHARED_HI) begin
      region = pmrb_pkg::PMRB_SHARED;
    end else if (req.addr <= `PMRB_OUT_HI) begin
      region = pmrb_pkg::PMRB_OUT_PG;
    end else if (req.addr >= `PMRB_EQ_LO && req.addr <= `PMRB_EQ_HI) begin
      region = pmrb_pkg::PMRB_SHARED;
    end else if (req.addr >= `PMRB_RX_LO && req.addr <= `PMRB_RX_HI) begin
      region = pmrb_pkg::PMRB_RX_PG;
    end else if (req.addr >= `PMRB_ODBG_LO && req.addr <= `PMRB_ODBG_HI) begin
      region = pmrb_pkg::PMRB_SHARED;
    end else if (req.addr >= `PMRB_IND_LO && req.addr <= `PMRB_IND_HI) begin
      region = pmrb_pkg::PMRB_SHARED;
    end else if (req.addr >= `PMRB_RDBG_LO && req.addr <= `PMRB_RDBG_HI) begin
      region = pmrb_pkg::PMRB_RX_PG;
    end else if ((req.addr >= `PMRB_ID_LO && req.addr <= `PMRB_ID_HI) ||
                 (req.addr >= `PMRB_PADDR_LO && req.addr <= `PMRB_PADDR_HI))
    begin
      region = pmrb_pkg::PMRB_SHARED;
    end else begin
      region = pmrb_pkg::PMRB_RSVD;
    end
  end

  // Four pages of 256: rx port n uses page n, page 0 also holds the rest.
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = {2'h0, req.addr};
    if (bcast_busy) begin
      mem_we    = 1'b1;
      mem_waddr = {bcast_left[3] ? 2'h3 : bcast_left[2] ? 2'h2 :
                   bcast_left[1] ? 2'h1 : 2'h0, bcast_addr};
    end else if (req.wr && !full_rst) begin
      unique case (region)
        pmrb_pkg::PMRB_SHARED: begin
          mem_we = req.addr != `PMRB_ADDR_TARGET &&
                   req.addr != `PMRB_ADDR_SOFT_RESET_CONTROL &&
                   req.addr != `PMRB_ADDR_STATUS;
        end
        pmrb_pkg::PMRB_OUT_PG: begin
          mem_we    = out_page[`PMRB_BIT_OUT_WEN];
        end
        pmrb_pkg::PMRB_RX_PG: begin
          mem_we    = 1'b0; // Handled by the broadcast walker below.
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end
  assign wport_mask = rx_page[3:0];

  // Broadcast writes walk the enabled rx ports one per cycle.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      bcast_busy <= 1'b0;
      bcast_left <= 4'h0;
      bcast_addr <= `PMRB_RST_BYTE;
      bcast_data <= `PMRB_RST_BYTE;
    end else if (!bcast_busy && req.wr && !full_rst &&
                 region == pmrb_pkg::PMRB_RX_PG && wport_mask != 4'h0) begin
      bcast_busy <= 1'b1;
      bcast_left <= wport_mask;
      bcast_addr <= req.addr;
      bcast_data <= req.wdata;
    end else if (bcast_busy) begin
      bcast_left <= bcast_left & ~(bcast_left[3] ? 4'h8 : bcast_left[2] ?
                    4'h4 : bcast_left[1] ? 4'h2 : 4'h1);
      bcast_busy <= (bcast_left & (bcast_left - 4'h1)) != 4'h0;
    end
  end

  // Read page selection for the memory.
  always_comb begin
    mem_raddr = {2'h0, req.addr};
    if (region == pmrb_pkg::PMRB_RX_PG) begin
      mem_raddr = {rx_page[`PMRB_RX_RSEL_LO +: 2], req.addr};
    end
  end

  // Rx pages live in one memory page per port, shared range in the low page.
  pmrb_ram u_ram (
    .CLK_IN    (CLK_IN),
    .we_in     (mem_we),
    .waddr_in  (bcast_busy ? mem_waddr : {2'h0, mem_waddr[7:0]}),
    .wdata_in  (bcast_busy ? bcast_data : req.wdata),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  // Strap capture happens after reset release, never under the async reset.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strap_taken <= 1'b0;
      strap_latch <= 7'h00;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_latch <= STRAP_ADDR_IN;
    end
  end

  // Target address register and override select.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      override    <= 1'b0;
      target_addr <= 7'h00;
    end else if (full_rst) begin
      override    <= 1'b0;
      target_addr <= strap_latch;
    end else if (!strap_taken) begin
      target_addr <= STRAP_ADDR_IN;
    end else if (req.wr && req.addr == `PMRB_ADDR_TARGET) begin
      override <= req.wdata[`PMRB_BIT_OVERRIDE];
      if (req.wdata[`PMRB_BIT_OVERRIDE]) begin
        target_addr <= req.wdata[7:1];
      end else begin
        target_addr <= strap_latch;
      end
    end else if (!override) begin
      target_addr <= strap_latch;
    end
  end
  assign TARGET_ADDR_OUT = target_addr;

  // Paging registers; kept through the register-preserving reset.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      out_page <= `PMRB_RST_BYTE;
      rx_page  <= `PMRB_RST_BYTE;
    end else if (full_rst) begin
      out_page <= `PMRB_RST_BYTE;
      rx_page  <= `PMRB_RST_BYTE;
    end else if (req.wr && req.addr == `PMRB_ADDR_OUT_PAGE) begin
      out_page <= req.wdata;
    end else if (req.wr && req.addr == `PMRB_ADDR_RX_PAGE) begin
      rx_page <= req.wdata;
    end
  end

  // Soft reset pulses; bits self-clear so they always read zero afterwards.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      full_rst      <= 1'b0;
      LOGIC_RST_OUT <= 1'b0;
    end else begin
      full_rst      <= req.wr && req.addr == `PMRB_ADDR_SOFT_RESET_CONTROL &&
                       req.wdata[`PMRB_BIT_FULL_RST];
      LOGIC_RST_OUT <= req.wr && req.addr == `PMRB_ADDR_SOFT_RESET_CONTROL &&
                       (req.wdata[`PMRB_BIT_KEEP_RST] ||
                        req.wdata[`PMRB_BIT_FULL_RST]);
    end
  end

  // ROM load sequencer; reload or full reset restarts the count.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      load_state <= pmrb_pkg::PMRB_LOADING;
      load_cnt   <= 6'h00;
    end else if (full_rst || (req.wr && req.addr == `PMRB_ADDR_SOFT_RESET_CONTROL &&
                              req.wdata[`PMRB_BIT_RELOAD])) begin
      load_state <= pmrb_pkg::PMRB_LOADING;
      load_cnt   <= 6'h00;
    end else begin
      unique case (load_state)
        pmrb_pkg::PMRB_LOADING: begin
          load_cnt <= load_cnt + 6'h01;
          if (load_cnt == `PMRB_LOAD_CYCLES - 6'h01) begin
            load_state <= pmrb_pkg::PMRB_READY;
          end
        end
        pmrb_pkg::PMRB_READY: begin
          load_cnt <= load_cnt;
        end
        default: begin
          load_state <= pmrb_pkg::PMRB_LOADING;
        end
      endcase
    end
  end
  assign INIT_DONE_OUT = load_state == pmrb_pkg::PMRB_READY;

  // Directly held registers answer from here; others from the memory.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_pend <= 1'b0;
      rd_mem  <= 1'b0;
      rd_reg  <= `PMRB_RST_BYTE;
    end else begin
      rd_pend <= req.rd;
      rd_mem  <= 1'b0;
      rd_reg  <= `PMRB_RST_BYTE;
      if (req.rd) begin
        if (req.addr == `PMRB_ADDR_TARGET) begin
          rd_reg <= {target_addr, override};
        end else if (req.addr == `PMRB_ADDR_SOFT_RESET_CONTROL) begin
          rd_reg <= `PMRB_RST_BYTE;
        end else if (req.addr == `PMRB_ADDR_STATUS) begin
          rd_reg[`PMRB_BIT_INIT_DONE] <= INIT_DONE_OUT;
        end else if (req.addr == `PMRB_ADDR_OUT_PAGE) begin
          rd_reg <= out_page;
        end else if (req.addr == `PMRB_ADDR_RX_PAGE) begin
          rd_reg <= rx_page;
        end else if (region == pmrb_pkg::PMRB_OUT_PG) begin
          rd_mem <= !out_page[`PMRB_BIT_OUT_RSEL];
        end else if (region != pmrb_pkg::PMRB_RSVD) begin
          rd_mem <= 1'b1;
        end
      end
    end
  end

  // Read data register; reserved space reads zero.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT  <= `PMRB_RST_BYTE;
      RVALID_OUT <= 1'b0;
    end else begin
      RVALID_OUT <= rd_pend;
      RDATA_OUT  <= rd_mem ? mem_rdata : rd_reg;
    end
  end

  // Assertions.
  a_init_after_reload: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) (req.wr && req.addr == `PMRB_ADDR_SOFT_RESET_CONTROL &&
    req.wdata[`PMRB_BIT_RELOAD]) |=> !INIT_DONE_OUT [*8])
    else $error("Init done did not drop after reload.");
  a_init_done_time: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) $rose(INIT_DONE_OUT) |->
    $past(load_cnt) == `PMRB_LOAD_CYCLES - 6'h01)
    else $error("Init done rose at wrong count.");
  a_addr_strap_hold: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) (strap_taken && !override && !$past(override))
    |-> target_addr == strap_latch || $past(full_rst))
    else $error("Target address left strap without override.");
  a_addr_override_wr: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) (strap_taken && !full_rst && req.wr &&
    req.addr == `PMRB_ADDR_TARGET && req.wdata[`PMRB_BIT_OVERRIDE])
    |=> TARGET_ADDR_OUT == $past(req.wdata[7:1]))
    else $error("Override write not adopted.");
  a_full_rst_clear: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) full_rst |=> !override &&
    rx_page == `PMRB_RST_BYTE && out_page == `PMRB_RST_BYTE &&
    target_addr == strap_latch)
    else $error("Full reset left registers set.");
  a_keep_rst_regs: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) (!full_rst && req.wr &&
    req.addr == `PMRB_ADDR_SOFT_RESET_CONTROL && req.wdata[`PMRB_BIT_KEEP_RST] &&
    !req.wdata[`PMRB_BIT_FULL_RST]) |=> LOGIC_RST_OUT &&
    rx_page == $past(rx_page) && out_page == $past(out_page) &&
    override == $past(override))
    else $error("Keep-registers reset altered paging.");
  a_rsvd_read_zero: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) (req.rd && region == pmrb_pkg::PMRB_RSVD)
    |-> ##2 RDATA_OUT == `PMRB_RST_BYTE && RVALID_OUT)
    else $error("Reserved read not zero.");
  a_out_page_gate: assert property (@(posedge CLK_IN)
    disable iff (!RST_N_IN) (!bcast_busy &&
    region == pmrb_pkg::PMRB_OUT_PG && !out_page[`PMRB_BIT_OUT_WEN])
    |-> !mem_we)
    else $error("Output page written while disabled.");
endmodule

// File: pmrb_host_model.sv
`timescale 1ns/1ps
// Control-channel host: one address byte and one data byte per access.
module pmrb_host_model (
  input  wire logic       clk_in,    // Clock.
  input  wire logic       busy_in,   // Channel stall from the bank.
  output logic            wr_out,    // Write strobe.
  output logic            rd_out,    // Read strobe.
  output logic      [7:0] addr_out,  // Register address.
  output logic      [7:0] wdata_out  // Write data.
);
  // Idle bus values.
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // A refused request is held until an edge takes it; gap makes a slow host.
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input int gap);
    repeat (gap) @(negedge clk_in);
    @(negedge clk_in);
    wr_out = wr;
    rd_out = !wr;
    addr_out = a;
    wdata_out = d;
    #1;
    while (busy_in === 1'b1) begin
      @(negedge clk_in);
      #1;
    end
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // Released lines show the inverse, so stale values never pass.
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

// File: pmrb_top_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the paged main register bank.
module pmrb_top_tb_top;
  localparam logic [6:0] STRAP = 7'h2d;
  logic [6:0] strap;
  logic       clk;
  logic       rst_n;
  logic       lw;
  logic       lr;
  logic [7:0] laddr;
  logic [7:0] lwdata;
  logic       cwr;
  logic       crd_s;
  logic [7:0] caddr;
  logic [7:0] cwdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       busy;
  logic       lrst;
  logic       idone;
  logic [6:0] taddr;
  logic [7:0] last_rd;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         n_rst = 0;
  int         n_busy = 0;

  pmrb_top i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .STRAP_ADDR_IN(strap),
    .LCL_WR_IN(lw), .LCL_RD_IN(lr), .LCL_ADDR_IN(laddr),
    .LCL_WDATA_IN(lwdata), .CH_WR_IN(cwr), .CH_RD_IN(crd_s),
    .CH_ADDR_IN(caddr), .CH_WDATA_IN(cwdata), .RDATA_OUT(rdata),
    .RVALID_OUT(rvalid), .CH_BUSY_OUT(busy), .TARGET_ADDR_OUT(taddr),
    .LOGIC_RST_OUT(lrst), .INIT_DONE_OUT(idone));

  pmrb_host_model i_host (.clk_in(clk), .busy_in(busy), .wr_out(cwr),
    .rd_out(crd_s), .addr_out(caddr), .wdata_out(cwdata));

  // Clock, 8 ns period.
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Sample mid-cycle so outputs launched by the edge have settled.
  always @(negedge clk) begin
    if (rvalid === 1'b1) last_rd = rdata;
    if (lrst === 1'b1) n_rst++;
    if (busy === 1'b1) n_busy++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Local write; the idle tail covers a four-port broadcast walk.
  task automatic lwr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    lw = 1'b1;
    laddr = a;
    lwdata = d;
    @(negedge clk);
    lw = 1'b0;
    laddr = ~a;
    lwdata = ~d;
    repeat (5) @(negedge clk);
  endtask

  // Local read; valid stands in the second cycle after the read is taken.
  task automatic lrd(input logic [7:0] a, input logic [7:0] exp,
                     input logic [7:0] m = 8'hff);
    @(negedge clk);
    lr = 1'b1;
    laddr = a;
    @(negedge clk);
    lr = 1'b0;
    laddr = ~a;
    check({7'h00, rvalid}, 8'h00);
    @(negedge clk);
    check({7'h00, rvalid}, 8'h01);
    check(rdata & m, exp);
  endtask

  task automatic crd(input logic [7:0] a, input logic [7:0] exp);
    last_rd = 8'hxx;
    i_host.access(1'b0, a, 8'h00, 2);
    repeat (3) @(negedge clk);
    check(last_rd, exp);
  endtask

  task automatic t_init();
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (30) @(negedge clk);
    // Straps move after capture; the latched address must not follow.
    strap = ~STRAP;
    check({7'h00, idone}, 8'h00);
    repeat (4) @(negedge clk);
    check({7'h00, idone}, 8'h01);
    check({1'b0, taddr}, {1'b0, STRAP});
    lrd(8'h00, {STRAP, 1'b0});
  endtask

  task automatic t_addr();
    lwr(8'h00, 8'h54);
    lrd(8'h00, {STRAP, 1'b0});
    i_host.access(1'b1, 8'h00, 8'h55, 3);
    repeat (2) @(negedge clk);
    check({1'b0, taddr}, 8'h2a);
    crd(8'h00, 8'h55);
    lwr(8'h00, 8'h00);
    check({1'b0, taddr}, {1'b0, STRAP});
  endtask

  task automatic t_out();
    lwr(8'h32, 8'h01);
    lwr(8'h33, 8'h5a);
    lwr(8'h32, 8'h00);
    lwr(8'h33, 8'hff);
    lrd(8'h33, 8'h5a);
    lwr(8'h32, 8'h10);
    lrd(8'h33, 8'h00);
  endtask

  // Broadcast to all ports, then overwrite port 2 alone.
  task automatic t_rx();
    logic [7:0] ra [2] = '{8'h50, 8'hd5};
    for (int i = 0; i < 2; i++) begin
      lwr(8'h4c, 8'h0f);
      lwr(ra[i], 8'ha5);
      lwr(8'h4c, 8'h04);
      lwr(ra[i], 8'h3c);
      for (int p = 0; p < 4; p++) begin
        lwr(8'h4c, {2'b00, p[1:0], 4'h0});
        lrd(ra[i], (p == 2) ? 8'h3c : 8'ha5);
      end
    end
  endtask

  // Written with port 0 paged in, read back with port 3 paged in.
  task automatic t_shared();
    logic [7:0] sa [8] = '{8'h90, 8'h9f, 8'hf0, 8'hf5, 8'h41, 8'hb5,
                           8'hf9, 8'h20};
    lwr(8'h4c, 8'h01);
    foreach (sa[i]) lwr(sa[i], sa[i] ^ 8'h3c);
    lwr(8'h4c, 8'h38);
    foreach (sa[i]) lrd(sa[i], sa[i] ^ 8'h3c);
  endtask

  task automatic t_rsvd();
    logic [7:0] za [7] = '{8'h3c, 8'h85, 8'ha5, 8'hc5, 8'he5, 8'hf6,
                           8'hfd};
    foreach (za[i]) lwr(za[i], 8'hff);
    foreach (za[i]) lrd(za[i], 8'h00);
    lwr(8'h04, 8'h00);
    lrd(8'h04, 8'h40, 8'h40);
  endtask

  // Local wins the same edge; the channel waits out the broadcast walk.
  task automatic t_chan();
    lwr(8'h4c, 8'h0f);
    fork
      lwr(8'h60, 8'h99);
      i_host.access(1'b1, 8'h61, 8'h66, 0);
    join
    repeat (5) @(negedge clk);
    check({7'h00, n_busy > 0}, 8'h01);
    lwr(8'h4c, 8'h20);
    lrd(8'h60, 8'h99);
    crd(8'h61, 8'h66);
  endtask

  task automatic t_rst();
    int k;
    k = 0;
    lwr(8'h20, 8'h77);
    // Keep-config reset is the preferred soft reset.
    lwr(8'h01, 8'h01);
    check(n_rst[7:0], 8'h01);
    lrd(8'h20, 8'h77);
    lrd(8'h01, 8'h00);
    lwr(8'h01, 8'h04);
    check({7'h00, idone}, 8'h00);
    // Poll the done flag before trusting reloaded settings.
    while (idone !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    check({7'h00, idone}, 8'h01);
    lrd(8'h01, 8'h00);
    lwr(8'h00, 8'h55);
    lwr(8'h01, 8'h02);
    check(n_rst[7:0], 8'h02);
    check({7'h00, idone}, 8'h00);
    repeat (40) @(negedge clk);
    check({1'b0, taddr}, {1'b0, STRAP});
    lrd(8'h00, {STRAP, 1'b0});
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    strap = STRAP;
    lw = 1'b0;
    lr = 1'b0;
    laddr = 8'h00;
    lwdata = 8'h00;
    t_init();
    t_addr();
    t_out();
    t_rx();
    t_shared();
    t_rsvd();
    t_chan();
    t_rst();
    stop_test();
  end

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #(8 * 20000);
    n_mismatch++;
    stop_test();
  end
endmodule
